// [logic/bsm_core.sv]
`timescale 1ns/10ps
// Behaviour
// RULE_01: start held one clock at least; packet begins at next symbol tick.
// RULE_02: start pulse is remembered even if it falls before the tick.
// RULE_03: transmit-active rises at first tick, lasts packet-length symbols.
// RULE_04: transmit register rotates, bit 127 feeding bit 0.
// RULE_05: after 128 ticks rotation stops when start low; data restored.
// RULE_06: no new packet before 128 symbols; restart resends same data.
// RULE_07: start still high at packet end relaunches on the 129th tick.
// RULE_08: mode 0 shows register msb first on frequency select.
// RULE_09: mode 0 transmitting shifts data to symbol bit 0; bit 1 zero.
// RULE_10: oscillator adds 8-bit word each clock, carry dropped.
// RULE_11: oscillator output is the accumulator msb.
// RULE_12: symbol tick comes from second oscillator with own word.
// RULE_13: mux passes word a on select 0, word b on select 1.
// RULE_14: mux words and select are registered on the system clock.
// RULE_15: switch output 1 turns transistor on, 0 off.
// RULE_16: mode 0 switches 001 only when active and modulation high.
// RULE_17: mode 1 decodes symbol to one-hot switch, ignoring modulation.
// RULE_18: load rising edge copies 128-bit config into transmit register; a rotating tick in the same clock overrides the copy.
// RULE_19: config feeding logic changes only when a write completes.
// RULE_20: start edge sets a pending flag cleared by the launching tick.
module bsm_core
  import bsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic startPin,
  input wire logic loadPin,
  output logic [2:0] antSwitch,
  output logic txActive,
  output logic fsel
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] startSync_r;
  logic [1:0] loadSync_r;
  logic startS;
  logic loadS;

  // two flops each; only the second stage is read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startSync_r <= 2'h0;
      loadSync_r <= 2'h0;
    end else begin
      startSync_r <= {startSync_r[0], startPin};
      loadSync_r <= {loadSync_r[0], loadPin};
    end
  end
  assign startS = startSync_r[1];
  assign loadS = loadSync_r[1];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bsm_state_t st_r;
  bsm_state_t st_nxt;
  logic apbAcc;
  logic apbWr;
  logic apbBad;
  logic mode;
  logic modSel;
  logic [7:0] pktLen;
  logic symTick;
  logic startRise;
  logic loadRise;
  logic modOut;
  logic symOut;
  logic [7:0] muxWord;

  // zero-wait slave: access phase always completes
  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign apbBad = !(paddr == BSM_A_CTRL || paddr == BSM_A_FCW ||
                    paddr == BSM_A_STAT ||
                    (paddr >= BSM_A_DATA0 && paddr <= BSM_A_DATA3 &&
                     paddr[1:0] == 2'h0));
  assign pready = 1'b1;
  assign pslverr = apbAcc && apbBad;

  // live configuration fields
  assign mode = st_r.cfg.ctrl[0];
  assign modSel = st_r.cfg.ctrl[1];
  assign pktLen = st_r.cfg.ctrl[15:8];

  // ------------------------------------------------------------
  // oscillators
  // ------------------------------------------------------------
  // modulation oscillator, word chosen by the registered mux
  bsm_nco #(
    .ACC_W(BSM_FCW_W)
  ) i_bsm_nco_mod (
    .clk(clk),
    .rst_n(rst_n),
    .fcw(muxWord), // RULE_13
    .out(modOut) // RULE_10 RULE_11
  );

  // same clock, so the symbol tick needs no crossing logic
  bsm_nco #(
    .ACC_W(BSM_FCW_W)
  ) i_bsm_nco_sym (
    .clk(clk),
    .rst_n(rst_n),
    .fcw(st_r.cfg.fcw[23:16]), // RULE_12
    .out(symOut)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    startRise = startS && !st_r.startPrev;
    loadRise = loadS && !st_r.loadPrev;
    st_nxt.startPrev = startS;
    st_nxt.loadPrev = loadS;

    // register writes land only at completed access
    if (apbWr) begin // RULE_19
      case (paddr)
        BSM_A_CTRL: st_nxt.cfg.ctrl = pwdata;
        BSM_A_FCW: st_nxt.cfg.fcw = pwdata;
        BSM_A_DATA0: st_nxt.cfg.cfgData[31:0] = pwdata;
        BSM_A_DATA0 + 8'h04: st_nxt.cfg.cfgData[63:32] = pwdata;
        BSM_A_DATA0 + 8'h08: st_nxt.cfg.cfgData[95:64] = pwdata;
        BSM_A_DATA3: st_nxt.cfg.cfgData[127:96] = pwdata;
        default: st_nxt.cfg = st_r.cfg;
      endcase
    end

    // read data registered for the access cycle
    case (paddr)
      BSM_A_CTRL: st_nxt.prdata = st_r.cfg.ctrl;
      BSM_A_FCW: st_nxt.prdata = st_r.cfg.fcw;
      BSM_A_STAT: st_nxt.prdata = {16'h0, st_r.txCnt, 4'h0,
                                   st_r.pending, st_r.symbol,
                                   st_r.txOn};
      BSM_A_DATA0: st_nxt.prdata = st_r.cfg.cfgData[31:0];
      BSM_A_DATA0 + 8'h04: st_nxt.prdata = st_r.cfg.cfgData[63:32];
      BSM_A_DATA0 + 8'h08: st_nxt.prdata = st_r.cfg.cfgData[95:64];
      BSM_A_DATA3: st_nxt.prdata = st_r.cfg.cfgData[127:96];
      default: st_nxt.prdata = 32'h0;
    endcase

    // mux inputs registered on the oscillator clock
    st_nxt.wordA = st_r.cfg.fcw[7:0]; // RULE_14
    st_nxt.wordB = st_r.cfg.fcw[15:8]; // RULE_14
    st_nxt.selR = modSel; // RULE_14
    muxWord = st_r.selR ? st_r.wordB : st_r.wordA; // RULE_13

    // tick is the one-clock rising edge of the symbol oscillator
    st_nxt.symPrev = symOut;
    symTick = symOut && !st_r.symPrev; // RULE_12

    // load edge restores the transmit register
    if (loadRise) begin
      st_nxt.txData = st_r.cfg.cfgData; // RULE_18
    end

    // remember start edge until a tick consumes it
    if (startRise) begin
      st_nxt.pending = 1'b1; // RULE_02 RULE_20
    end

    if (symTick) begin
      case (st_r.phase)
        BSM_IDLE, BSM_ARMED: begin
          if (st_r.pending || startRise) begin // RULE_01
            // clear beats set when edge and tick coincide
            st_nxt.pending = 1'b0; // RULE_20
            st_nxt.phase = BSM_SEND;
            st_nxt.symCnt = BSM_CNT_RST + 8'h01;
            st_nxt.txCnt = pktLen;
            st_nxt.txOn = (pktLen != BSM_CNT_RST); // RULE_03
            st_nxt.fsel = st_r.txData[127]; // RULE_08
            st_nxt.txData = {st_r.txData[126:0], st_r.txData[127]}; // RULE_04
          end
        end
        BSM_SEND: begin
          // active time counts symbols from the length word
          if (st_r.txCnt > 8'h01) begin
            st_nxt.txCnt = st_r.txCnt - 8'h01;
          end else begin
            st_nxt.txCnt = BSM_CNT_RST;
            st_nxt.txOn = 1'b0; // RULE_03
          end
          if (st_r.symCnt == BSM_PKT_SYMS) begin
            // full rotation done: data back in load order
            if (startS) begin // RULE_07
              st_nxt.pending = 1'b0;
              st_nxt.symCnt = BSM_CNT_RST + 8'h01;
              st_nxt.txCnt = pktLen;
              st_nxt.txOn = (pktLen != BSM_CNT_RST);
              st_nxt.fsel = st_r.txData[127];
              st_nxt.txData = {st_r.txData[126:0], st_r.txData[127]};
            end else begin
              st_nxt.phase = st_r.pending ? BSM_ARMED : BSM_IDLE; // RULE_05
              st_nxt.txOn = 1'b0;
            end
          end else begin
            // earlier start edges wait in pending
            st_nxt.symCnt = st_r.symCnt + 8'h01; // RULE_06
            st_nxt.fsel = st_r.txData[127]; // RULE_08
            st_nxt.txData = {st_r.txData[126:0], st_r.txData[127]}; // RULE_04
          end
        end
        default: st_nxt.phase = BSM_IDLE;
      endcase
    end

    // mode 0 symbol: data on bit 0, bit 1 held low
    if (mode == 1'b0) begin
      st_nxt.symbol = {1'b0, st_nxt.txOn && st_nxt.fsel}; // RULE_09
    end else begin
      st_nxt.symbol = st_nxt.fsel ? 2'h1 : 2'h0;
    end

    // switch mapper, 1 means transistor on
    if (mode == 1'b0) begin
      st_nxt.sw = (st_r.txOn && modOut) ? BSM_SW_0 : BSM_SW_OFF; // RULE_16
    end else begin
      case (st_r.symbol) // RULE_17
        2'h0: st_nxt.sw = BSM_SW_OFF;
        2'h1: st_nxt.sw = BSM_SW_0;
        2'h2: st_nxt.sw = BSM_SW_1;
        default: st_nxt.sw = BSM_SW_2;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r.cfg.ctrl <= BSM_CTRL_RST;
      st_r.cfg.fcw <= BSM_FCW_RST;
      st_r.cfg.cfgData <= BSM_DATA_RST;
      st_r.txData <= BSM_DATA_RST;
      st_r.symPrev <= 1'b0;
      st_r.startPrev <= 1'b0;
      st_r.loadPrev <= 1'b0;
      st_r.pending <= 1'b0;
      st_r.phase <= BSM_IDLE;
      st_r.symCnt <= BSM_CNT_RST;
      st_r.txCnt <= BSM_CNT_RST;
      st_r.txOn <= 1'b0;
      st_r.symbol <= 2'h0;
      st_r.fsel <= 1'b0;
      st_r.wordA <= BSM_ACC_RST;
      st_r.wordB <= BSM_ACC_RST;
      st_r.selR <= 1'b0;
      st_r.sw <= BSM_SW_OFF;
      st_r.prdata <= 32'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = st_r.prdata;
  assign antSwitch = st_r.sw; // RULE_15
  assign txActive = st_r.txOn;
  assign fsel = st_r.fsel;
endmodule

// ------------------------------------------------------------
// phase accumulator oscillator
// ------------------------------------------------------------
module bsm_nco
  import bsm_pkg::*;
#(
  parameter int ACC_W = BSM_FCW_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ACC_W-1:0] fcw,
  output logic out
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;

  // sum kept at accumulator width, so the carry is dropped
  always_comb begin
    acc_nxt = acc_r + fcw; // RULE_10
  end

  // sync reset like the rest of the block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= ACC_W'(BSM_ACC_RST);
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // only the msb leaves; high and low times may differ by a clock
  assign out = acc_r[ACC_W-1]; // RULE_11
endmodule

// [logic/bsm_pkg.sv]
package bsm_pkg;
  // ------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------
  localparam int BSM_DATA_W = 128;
  localparam int BSM_FCW_W = 8;
  localparam int BSM_LEN_W = 8;
  localparam logic [7:0] BSM_PKT_SYMS = 8'h80;
  localparam logic [7:0] BSM_CNT_RST = 8'h00;
  localparam logic [7:0] BSM_ACC_RST = 8'h00;
  localparam logic [127:0] BSM_DATA_RST = 128'h0;

  // ------------------------------------------------------------
  // switch codes
  // ------------------------------------------------------------
  localparam logic [2:0] BSM_SW_OFF = 3'h0;
  localparam logic [2:0] BSM_SW_0 = 3'h1;
  localparam logic [2:0] BSM_SW_1 = 3'h2;
  localparam logic [2:0] BSM_SW_2 = 3'h4;

  // ------------------------------------------------------------
  // register bus offsets
  // ------------------------------------------------------------
  localparam logic [7:0] BSM_A_CTRL = 8'h00;
  localparam logic [7:0] BSM_A_FCW = 8'h04;
  localparam logic [7:0] BSM_A_STAT = 8'h08;
  localparam logic [7:0] BSM_A_DATA0 = 8'h10;
  localparam logic [7:0] BSM_A_DATA3 = 8'h1C;
  localparam logic [31:0] BSM_CTRL_RST = 32'h0;
  localparam logic [31:0] BSM_FCW_RST = 32'h0;

  typedef enum logic [1:0] {BSM_IDLE, BSM_ARMED, BSM_SEND} bsm_phase_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] fcw;
    logic [127:0] cfgData;
  } bsm_cfg_t;

  typedef struct packed {
    bsm_cfg_t cfg;
    logic [127:0] txData;
    logic symPrev;
    logic startPrev;
    logic loadPrev;
    logic pending;
    bsm_phase_t phase;
    logic [7:0] symCnt;
    logic [7:0] txCnt;
    logic txOn;
    logic [1:0] symbol;
    logic fsel;
    logic [7:0] wordA;
    logic [7:0] wordB;
    logic selR;
    logic [2:0] sw;
    logic [31:0] prdata;
  } bsm_state_t;
endpackage

// [testbench/bsm_checker.sv]
`timescale 1ns/10ps
module bsm_checker
  import bsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic startPin,
  input wire logic loadPin,
  input wire logic [2:0] antSwitch,
  input wire logic txActive,
  input wire logic fsel
);
  // ------------------------------------------------------------
  // shadow of the control word
  // ------------------------------------------------------------
  logic mode_r;
  logic [7:0] len_r;
  logic mapped;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14,
    8'h18, 8'h1C};
  // updates on the same edge as the design's own copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= 1'b0;
      len_r <= 8'h00;
    end else if (psel && penable && pwrite && paddr == BSM_A_CTRL) begin
      mode_r <= pwdata[0];
      len_r <= pwdata[15:8];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RST_QUIET: assert property (disable iff (1'b0)
    !rst_n |=> !txActive && antSwitch == 3'h0 && !fsel)
    else $error("outputs not cleared by reset");
  AST_UNMAPPED: assert property (psel && penable && !mapped
    |-> pslverr && prdata == 32'h0) else $error("unmapped access");
  AST_MAPPED_OK: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped access");
  AST_ONEHOT: assert property ($onehot0(antSwitch))
    else $error("more than one switch on");
  AST_M0_UPPER_OFF: assert property
    (!$past(mode_r) |-> antSwitch[2:1] == 2'b00) else $error("upper on");
  AST_M0_TX_GATE: assert property
    (!$past(mode_r) && !$past(txActive) |-> antSwitch == 3'h0)
    else $error("switch on while idle");
  AST_LEN_ZERO: assert property
    (len_r == 8'h00 && !txActive |=> !txActive)
    else $error("active with zero length");
  AST_M1_DECODE: assert property
    ((mode_r && $stable(fsel)) [*4] |-> antSwitch == {2'b00, fsel})
    else $error("symbol decode wrong");
  COV_TX_MOD: cover property (txActive && antSwitch[0]);
  COV_REFUSED: cover property (psel && penable && pslverr);
  COV_MODE1_TX: cover property (mode_r && txActive);
endmodule
bind bsm_core bsm_checker i_bsm_checker (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .startPin(startPin), .loadPin(loadPin), .antSwitch(antSwitch),
  .txActive(txActive), .fsel(fsel));

// [testbench/bsm_mcu_model.sv]
`timescale 1ns/10ps
module bsm_mcu_model
  import bsm_pkg::*;
(
  input wire logic clk,
  input wire logic startReq,
  input wire logic loadReq,
  input wire logic [2:0] antSwitch,
  output logic startPin,
  output logic loadPin,
  output int sw0Rises
);
  // ------------------------------------------------------------
  // controller pins and switch 0 transistor
  // ------------------------------------------------------------
  logic prev_r = 1'b0;
  int cnt_r = 0;
  // requests are whole clocks, so start is high one clock at least
  assign startPin = startReq;
  assign loadPin = loadReq;
  assign sw0Rises = cnt_r;
  // counts turn-on events; gate high means conducting
  always @(posedge clk) begin
    prev_r <= antSwitch[0];
    if (antSwitch[0] && !prev_r) cnt_r <= cnt_r + 1;
  end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fails++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top
  import bsm_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus and checks
  // ------------------------------------------------------------
  localparam logic [127:0] PAT_A = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [127:0] PAT_B = {PAT_A[63:0], ~PAT_A[127:64]};
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, startReq = 1'b0, loadReq = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, startPin, loadPin, txActive, fsel, err;
  logic [2:0] antSwitch;
  int sw0Rises, fails = 0, check_count = 0, cyc = 0, t0, r0;
  bsm_core i_bsm_core (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .startPin(startPin), .loadPin(loadPin), .antSwitch(antSwitch),
    .txActive(txActive), .fsel(fsel));
  bsm_mcu_model i_bsm_mcu_model (.clk(clk), .startReq(startReq),
    .loadReq(loadReq), .antSwitch(antSwitch), .startPin(startPin),
    .loadPin(loadPin), .sw0Rises(sw0Rises));
  // 25 ns period
  initial forever #12.5 clk = ~clk;
  // cycle stamp for spacing checks
  always @(posedge clk) cyc <= cyc + 1;
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; never assumes how soon pready comes
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK("prdata", e, q)
  endtask
  task automatic load(input logic [127:0] d);
    for (int k = 0; k < 4; k++) apb(BSM_A_DATA0 + 8'(4 * k), 1'b1,
      d[32*k +: 32]);
    loadReq <= 1'b1;
    clks(1);
    loadReq <= 1'b0;
    clks(4);
  endtask
  // samples mid-symbol so tick jitter of a clock or two is harmless
  task automatic runPkt(input logic [127:0] d);
    int n = 0;
    startReq <= 1'b1;
    clks(1);
    startReq <= 1'b0;
    while (txActive !== 1'b1) @(posedge clk);
    clks(32);
    for (int i = 0; i < 128; i++) begin
      `CHK("fsel", d[127 - i], fsel)
      n += (txActive === 1'b1);
      clks(64);
    end
    `CHK("tx symbols", 16, n)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // symbol word 4 gives 64 clocks a symbol, packet 8192 clocks
  initial begin
    clks(4);
    rst_n <= 1'b1;
    rd(BSM_A_CTRL, BSM_CTRL_RST);
    rd(BSM_A_FCW, BSM_FCW_RST);
    apb(BSM_A_FCW, 1'b1, 32'h0004_8040);
    rd(BSM_A_FCW, 32'h0004_8040);
    apb(BSM_A_CTRL, 1'b1, 32'h0000_1000);
    rd(8'h40, 32'h0);
    `CHK("pslverr", 1'b1, err)
    load(PAT_A);
    runPkt(PAT_A);
    runPkt(PAT_A);
    load(PAT_B);
    runPkt(PAT_B);
    startReq <= 1'b1;
    while (txActive !== 1'b1) @(posedge clk);
    t0 = cyc;
    r0 = sw0Rises;
    clks(256);
    `CHK("rises a", 64, sw0Rises - r0)
    apb(BSM_A_CTRL, 1'b1, 32'h0000_1002);
    clks(8);
    r0 = sw0Rises;
    clks(256);
    `CHK("rises b", 128, sw0Rises - r0)
    // ninth symbol: eight length counts left, data bit on symbol bit 0
    rd(BSM_A_STAT, {16'h0, 8'h08, 4'h0, 2'b00, PAT_B[119], 1'b1});
    while (txActive === 1'b1) @(posedge clk);
    while (txActive !== 1'b1) @(posedge clk);
    `CHK("relaunch", 8192, cyc - t0)
    t0 = cyc;
    startReq <= 1'b0;
    apb(BSM_A_CTRL, 1'b1, 32'h0000_1003);
    clks(29);
    for (int i = 0; i < 4; i++) begin
      `CHK("mode1 sw", {2'b00, fsel}, antSwitch)
      clks(64);
    end
    // short start pulse mid-packet waits for the packet to end
    startReq <= 1'b1;
    clks(1);
    startReq <= 1'b0;
    clks(4);
    apb(BSM_A_STAT, 1'b0, 32'h0);
    `CHK("pending", 1'b1, q[3])
    apb(BSM_A_CTRL, 1'b1, 32'h0000_0003);
    // after the 129th tick: still armed, nothing sent yet
    while (cyc - t0 < 8200) @(posedge clk);
    rd(BSM_A_STAT, 32'h0000_0008);
    // 130th tick launched: pending gone, zero length keeps tx low
    while (cyc - t0 < 8264) @(posedge clk);
    rd(BSM_A_STAT, 32'h0000_0002);
    results();
  end
  // run needs about 41k clocks; margin for slow launches
  initial begin
    #(60000 * 25);
    fails++;
    results();
  end
endmodule
